// file: can_transceiver_mode_wake_logic_bench.sv
// self-checking bench for the two-channel mode and wake logic
`timescale 1ns/1ns
module can_transceiver_mode_wake_logic_bench;
  import ctw_pkg::*;
  // short window and guard keep the run brief
  localparam logic [19:0] WIN = 20'h0_00C8;
  localparam logic [19:0] DOMINANT_TIMEOUT_GUARD = 20'h0_012C;
  logic       core_clk = 1'b0;
  logic       reset    = 1'b1;
  logic       clkEnable = 1'b1;
  logic       activeLow = 1'b0;
  logic [1:0] want = 2'h3;
  logic [1:0] tx   = 2'h3;
  logic [1:0] auto = 2'h0;
  logic [1:0] bus  = 2'h0;
  logic       wakeEventReady = 1'b0;
  logic       sel1, sel2, selL1, selL2, tx1, tx2, rx1, rx2;
  logic       dd1, dd2, de1, de2, wb1, wb2, wakeEventValid;
  logic [1:0] wakeEventMask;
  logic [7:0] falls1 = 8'h00;
  logic [7:0] falls2 = 8'h00;
  logic [7:0] f;
  logic [7:0] f2;
  int         failures = 0;
  int         compares = 0;
  int         pops;

  ctw_mode_wake #(.WINDOW_CYC(WIN), .DOM_TIMEOUT(DOMINANT_TIMEOUT_GUARD)) dut_u (
    .core_clk(core_clk), .reset(reset), .clkEnable(clkEnable), .activeLowVariant(activeLow),
    .standbySelectCh1(sel1), .standbySelectCh2(sel2), .standbySelectLowCh1(selL1),
    .standbySelectLowCh2(selL2), .transmitInCh1(tx1), .transmitInCh2(tx2),
    .busDominantCh1(bus[0]), .busDominantCh2(bus[1]), .receiveOutCh1(rx1), .receiveOutCh2(rx2),
    .driveDominantCh1(dd1), .driveDominantCh2(dd2), .driverEnableCh1(de1), .driverEnableCh2(de2),
    .weakGroundBiasCh1(wb1), .weakGroundBiasCh2(wb2), .wakeEventValid(wakeEventValid),
    .wakeEventMask(wakeEventMask), .wakeEventReady(wakeEventReady));
  ctw_ctrl_model ctrl1_u (.core_clk(core_clk), .receiveOut(rx1), .wantStandby(want[0]),
    .txLevel(tx[0]), .autoWake(auto[0]), .activeLow(activeLow), .standbySelect(sel1),
    .standbySelectLow(selL1), .transmitIn(tx1));
  ctw_ctrl_model ctrl2_u (.core_clk(core_clk), .receiveOut(rx2), .wantStandby(want[1]),
    .txLevel(tx[1]), .autoWake(auto[1]), .activeLow(activeLow), .standbySelect(sel2),
    .standbySelectLow(selL2), .transmitIn(tx2));

  // ----------------------------------------------------------------
  // clock, fall counters, helpers
  // ----------------------------------------------------------------
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  // falls of receive are what a controller would see as wake requests
  always @(negedge rx1) falls1 <= falls1 + 8'h01;
  always @(negedge rx2) falls2 <= falls2 + 8'h01;

  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs always move one nanosecond after the rising edge
  task tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task busHold(input int ch, input logic dom, input int n);
    bus[ch] = dom;
    tick(n);
  endtask
  task report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    tx = 2'h0;
    tick(3);
    check(rx1, 1'b1);
    check(dd1, 1'b0);
    check(de2, 1'b0);
    check(wb1, 1'b1);
    check(dd2, 1'b0);
    check(wakeEventValid, 1'b0);
    tx = 2'h3;
    $display("test reset done");
  endtask

  task t_normal_guard;
    want[1] = 1'b0;
    tick(3);
    tx[1] = 1'b0;
    bus[1] = 1'b1;
    tick(3);
    check(wb2, 1'b0);
    check(de2, 1'b1);
    check(dd2, 1'b1);
    check(rx2, 1'b0);
    check(wb1, 1'b1);
    tick(int'(DOMINANT_TIMEOUT_GUARD) - 8);
    check(de2, 1'b1);
    tick(8);
    check(de2, 1'b0);
    check(dd2, 1'b0);
    check(rx2, 1'b0);
    tx[1] = 1'b1;
    bus[1] = 1'b0;
    tick(3);
    check(de2, 1'b1);
    check(dd2, 1'b0);
    check(rx2, 1'b1);
    want[1] = 1'b1;
    tick(3);
    $display("test normal and guard done");
  endtask

  task t_wake_buffer;
    f  = falls1;
    f2 = falls2; // channel two already fell while mirroring the bus in normal mode
    repeat (3)
    begin
      busHold(0, 1'b1, 10);
      busHold(0, 1'b0, 30);
    end
    check(falls1, f);
    busHold(0, 1'b1, 30);
    busHold(0, 1'b0, 5);
    busHold(0, 1'b1, 5);
    busHold(0, 1'b0, 30);
    busHold(0, 1'b1, 5);
    busHold(0, 1'b0, 5);
    busHold(0, 1'b1, 30);
    check(falls1, f + 8'h01);
    check(rx1, 1'b0);
    check(falls2, f2);
    busHold(0, 1'b0, 2);
    check(rx1, 1'b1);
    repeat (2)
    begin
      busHold(0, 1'b1, 30);
      busHold(0, 1'b0, 30);
    end
    check(falls1, f + 8'h03);
    check(wakeEventValid, 1'b1);
    pops = 0;
    wakeEventReady = 1'b1;
    for (int i = 0; i < 20 && wakeEventValid === 1'b1; i++)
    begin
      check(wakeEventMask, 2'h1);
      pops++;
      tick(1);
    end
    tick(4);
    check(wakeEventValid, 1'b0);
    check(8'(pops), 8'h03);
    auto[0] = 1'b1;
    busHold(0, 1'b1, 30);
    busHold(0, 1'b0, 5);
    check(wb1, 1'b0);
    auto[0] = 1'b0;
    $display("test wake and buffer done");
  endtask

  task t_window;
    want[0] = 1'b0;
    tick(2);
    want[0] = 1'b1;
    tick(3);
    check(wb1, 1'b1);
    f = falls1;
    busHold(0, 1'b1, 30);
    check(falls1, f);
    busHold(0, 1'b0, 250);
    busHold(0, 1'b1, 30);
    check(falls1, f);
    busHold(0, 1'b0, 30);
    busHold(0, 1'b1, 30);
    check(falls1, f + 8'h01);
    busHold(0, 1'b0, 30);
    $display("test window done");
  endtask

  task t_variant;
    activeLow = 1'b1;
    tick(3);
    check(wb1, 1'b1);
    want[0] = 1'b0;
    tick(3);
    check(wb1, 1'b0);
    check(de1, 1'b1);
    want[0] = 1'b1;
    activeLow = 1'b0;
    tick(3);
    check(wb1, 1'b1);
    $display("test variant done");
  endtask

  // channel two wakes alone, its event is held for a stalled reader, then a mid-run reset
  task t_ch2_reset;
    f  = falls1;
    f2 = falls2;
    wakeEventReady = 1'b0;
    busHold(1, 1'b1, 30);
    busHold(1, 1'b0, 30);
    busHold(1, 1'b1, 30);
    check(falls2, f2 + 8'h01);
    check(falls1, f);
    check(rx2, 1'b0);
    check(wakeEventValid, 1'b1);
    check(wakeEventMask, 2'h2);
    wakeEventReady = 1'b1;
    tick(2);
    check(wakeEventValid, 1'b0);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    check(rx2, 1'b1);
    check(wb2, 1'b1);
    check(dd2, 1'b0);
    busHold(1, 1'b0, 30);
    check(falls2, f2 + 8'h01);
    check(rx2, 1'b1);
    $display("test channel two and reset done");
  endtask

  // a hang counts as a mismatch and closes the run
  initial
  begin
    repeat (60000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    tick(4);
    reset = 1'b0;
    tick(2);
    t_reset();
    t_normal_guard();
    t_wake_buffer();
    t_window();
    t_variant();
    t_ch2_reset();
    report_and_stop();
  end
endmodule

// file: ctw_ctrl_model.sv
// behavioural local protocol controller driving one channel's standby-select and transmit pins
`timescale 1ns/1ns
module ctw_ctrl_model(
  input  wire logic core_clk,
  input  wire logic receiveOut,
  input  wire logic wantStandby,
  input  wire logic txLevel,
  input  wire logic autoWake,
  input  wire logic activeLow,
  output logic      standbySelect,
  output logic      standbySelectLow,
  output logic      transmitIn
);
  logic prevRx = 1'b1;
  logic woke   = 1'b0;
  logic standbyNow;

  // watch receive for a fall while in standby; change pins just after the edge
  always @(posedge core_clk)
  begin
    #1;
    if (!wantStandby)
      woke = 1'b0;
    else if (autoWake && prevRx && !receiveOut)
      woke = 1'b1;
    prevRx = receiveOut;
  end

  // both select pins carry the chosen variant's level, so the unused one misleads
  assign standbyNow       = wantStandby && !woke;
  assign standbySelect    = activeLow ? !standbyNow : standbyNow;
  assign standbySelectLow = standbySelect;
  assign transmitIn       = txLevel;
endmodule

// file: ctw_mode_wake.sv
// two-channel standby/normal mode control, wake-pattern detection and dominant guard
`timescale 1ns/1ns

module ctw_mode_wake
  import ctw_pkg::*;
#(
  parameter logic [19:0] WINDOW_CYC  = WINDOW_CYC_DEF,
  parameter logic [19:0] DOM_TIMEOUT = DOM_TIMEOUT_DEF
)(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic clkEnable,
  input  wire logic activeLowVariant,
  input  wire logic standbySelectCh1,
  input  wire logic standbySelectCh2,
  input  wire logic standbySelectLowCh1,
  input  wire logic standbySelectLowCh2,
  input  wire logic transmitInCh1,
  input  wire logic transmitInCh2,
  input  wire logic busDominantCh1,
  input  wire logic busDominantCh2,
  output logic      receiveOutCh1,
  output logic      receiveOutCh2,
  output logic      driveDominantCh1,
  output logic      driveDominantCh2,
  output logic      driverEnableCh1,
  output logic      driverEnableCh2,
  output logic      weakGroundBiasCh1,
  output logic      weakGroundBiasCh2,
  output logic      wakeEventValid,
  output logic [1:0] wakeEventMask,
  input  wire logic wakeEventReady
);

  // ----------------------------------------------------------------
  // pin gathering
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] sbVec;
  logic [NUM_CH-1:0] txVec;
  logic [NUM_CH-1:0] busVec;

  // select the polarity variant; pad bias makes a floating pin read standby or recessive
  always_comb
  begin
    sbVec[0]  = activeLowVariant ? ~standbySelectLowCh1 : standbySelectCh1;
    sbVec[1]  = activeLowVariant ? ~standbySelectLowCh2 : standbySelectCh2;
    txVec     = {transmitInCh2, transmitInCh1};  // 1 = recessive
    busVec    = {busDominantCh2, busDominantCh1};
  end

  // ----------------------------------------------------------------
  // channel state
  // ----------------------------------------------------------------
  ctw_chan_t         st      [NUM_CH];
  ctw_chan_t         next_st [NUM_CH];
  ctw_pins_t         pins    [NUM_CH];
  ctw_pins_t         next_pins [NUM_CH];
  logic [NUM_CH-1:0] filtDom;
  logic [NUM_CH-1:0] filtRec;
  logic [NUM_CH-1:0] wakeHit;

  // one filtered event per held level; saturating run counter avoids repeats
  function automatic logic filtered(input ctw_chan_t s, input logic b);
    filtered = (b == s.lastBus) && (s.runCnt == FILTER_CYC - 6'h1);
  endfunction

  // next state of both channels; channels share nothing so a wake stays local
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      next_st[i]   = st[i];
      filtDom[i]   = filtered(st[i], busVec[i]) && busVec[i];
      filtRec[i]   = filtered(st[i], busVec[i]) && !busVec[i];
      wakeHit[i]   = 1'b0;
      next_st[i].standby = sbVec[i];
      next_st[i].lastBus = busVec[i];
      next_st[i].lastTx  = txVec[i];
      // saturating run-length counter restarts on every level change
      if (busVec[i] != st[i].lastBus)
        next_st[i].runCnt = RUN_RST;
      else if (st[i].runCnt != FILTER_CYC)
        next_st[i].runCnt = st[i].runCnt + 6'h1;
      if (!sbVec[i])
      begin
        next_st[i].wake      = WK_IDLE;
        next_st[i].windowCnt = CNT_RST;
        next_st[i].rxLow     = 1'b0;
      end
      else if (!st[i].standby)
      begin
        // fresh standby period starts the detector from idle
        next_st[i].wake      = WK_IDLE;
        next_st[i].windowCnt = CNT_RST;
        next_st[i].rxLow     = 1'b0;
      end
      else
      begin
        unique case (st[i].wake)
          WK_IDLE:
          begin
            if (filtDom[i])
            begin
              next_st[i].wake      = WK_WAIT_REC;
              next_st[i].windowCnt = CNT_RST;
            end
          end
          WK_WAIT_REC, WK_WAIT_DOM:
          begin
            // short glitches produce no filtered event, so they never restart us
            if (st[i].wake == WK_WAIT_DOM && filtDom[i])
            begin
              next_st[i].wake  = WK_AWAKE;
              next_st[i].rxLow = 1'b1;
              wakeHit[i]       = 1'b1;
            end
            else if (st[i].windowCnt == WINDOW_CYC - 20'h0_0001)
            begin
              next_st[i].wake      = WK_IDLE;
              next_st[i].windowCnt = CNT_RST;
            end
            else
            begin
              next_st[i].windowCnt = st[i].windowCnt + 20'h0_0001;
              if (st[i].wake == WK_WAIT_REC && filtRec[i])
                next_st[i].wake = WK_WAIT_DOM;
            end
          end
          WK_AWAKE:
          begin
            if (filtDom[i])
            begin
              next_st[i].rxLow = 1'b1;
              wakeHit[i]       = 1'b1;
            end
          end
        endcase
        // the low period lasts as long as the filtered dominant itself
        if (!busVec[i] && !(filtDom[i]))
          next_st[i].rxLow = 1'b0;
      end
      // dominant guard: armed by a falling transmit edge, only in normal mode
      if (sbVec[i] || txVec[i])
      begin
        next_st[i].dtoCnt  = CNT_RST;
        next_st[i].dtoTrip = 1'b0;
      end
      else if (st[i].lastTx)
        next_st[i].dtoCnt = 20'h0_0001;
      else if (!st[i].dtoTrip && st[i].dtoCnt != CNT_RST)
      begin
        if (st[i].dtoCnt == DOM_TIMEOUT - 20'h0_0001)
          next_st[i].dtoTrip = 1'b1;
        else
          next_st[i].dtoCnt = st[i].dtoCnt + 20'h0_0001;
      end
      // pins are registered so every output comes from a flop
      next_pins[i].weakGroundBias = sbVec[i];
      next_pins[i].driverEnable   = !sbVec[i] && !next_st[i].dtoTrip;
      next_pins[i].driveDominant  = !sbVec[i] && !txVec[i] && !next_st[i].dtoTrip;
      next_pins[i].receiveOut     = sbVec[i] ? !next_st[i].rxLow
                                             : !busVec[i];
    end
  end

  // register the channel state; clock enable freezes everything
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (reset)
      begin
        st[i]   <= '{standby: 1'b1, lastBus: 1'b0, runCnt: RUN_RST, wake: WK_IDLE,
                     windowCnt: CNT_RST, rxLow: 1'b0, lastTx: 1'b1, dtoCnt: CNT_RST, dtoTrip: 1'b0};
        pins[i] <= '{receiveOut: 1'b1, driveDominant: 1'b0, driverEnable: 1'b0, weakGroundBias: 1'b1};
      end
      else if (clkEnable)
      begin
        st[i]   <= next_st[i];
        pins[i] <= next_pins[i];
      end
    end
  end

  assign receiveOutCh1     = pins[0].receiveOut;
  assign receiveOutCh2     = pins[1].receiveOut;
  assign driveDominantCh1  = pins[0].driveDominant;
  assign driveDominantCh2  = pins[1].driveDominant;
  assign driverEnableCh1   = pins[0].driverEnable;
  assign driverEnableCh2   = pins[1].driverEnable;
  assign weakGroundBiasCh1 = pins[0].weakGroundBias;
  assign weakGroundBiasCh2 = pins[1].weakGroundBias;

  // ----------------------------------------------------------------
  // wake event buffer
  // ----------------------------------------------------------------
  logic [1:0] pendMask;
  logic [1:0] next_pendMask;
  logic [1:0] entry [BUF_DEPTH];
  logic [1:0] next_entry [BUF_DEPTH];
  logic [1:0] fill;
  logic [1:0] next_fill;
  logic       pop;
  logic       push;
  logic [1:0] slot;

  // a pending mask waits while the buffer is full and later hits are ORed into it, so a stalled reader loses no channel's wake
  always_comb
  begin
    next_entry = entry;
    pop        = (fill != FILL_EMPTY) && wakeEventReady;
    push       = (pendMask != MASK_NONE) && ((fill != FILL_FULL) || pop);
    slot       = fill - {1'b0, pop};
    if (pop)
    begin
      next_entry[0] = entry[1];
      next_entry[1] = MASK_NONE;
    end
    if (push)
      next_entry[slot[0]] = pendMask;
    next_fill     = fill + {1'b0, push} - {1'b0, pop};
    // a new hit in the cycle the pending mask leaves is kept, not lost
    next_pendMask = (push ? MASK_NONE : pendMask) | wakeHit;
  end

  // register the buffer; entry 0 is the head shown at the port
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pendMask <= MASK_NONE;
      fill     <= FILL_EMPTY;
      entry    <= '{default: MASK_NONE};
    end
    else if (clkEnable)
    begin
      pendMask <= next_pendMask;
      fill     <= next_fill;
      entry    <= next_entry;
    end
  end

  // valid is a flop copy of the fill level
  always_ff @(posedge core_clk)
  begin
    if (reset)
      wakeEventValid <= 1'b0;
    else if (clkEnable)
      wakeEventValid <= (next_fill != FILL_EMPTY);
  end

  assign wakeEventMask = entry[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_chk
    sequence s_last_dom;
      clkEnable && sbVec[g] && st[g].standby && st[g].wake == WK_WAIT_DOM && filtDom[g];
    endsequence

    a_mode_follow: assert property (clkEnable |=> pins[g].weakGroundBias == $past(sbVec[g]))
      else $error("mode does not follow select pin");
    a_standby_drv_off: assert property (pins[g].weakGroundBias |-> !pins[g].driverEnable && !pins[g].driveDominant)
      else $error("driver active in standby");
    a_normal_rx_mirror: assert property (clkEnable && !sbVec[g] |=> pins[g].receiveOut == !$past(busVec[g]))
      else $error("receive does not mirror bus");
    a_normal_tx_drive: assert property (clkEnable && !sbVec[g] && txVec[g] |=> !pins[g].driveDominant)
      else $error("dominant driven while transmit recessive");
    a_wake_recognize: assert property (s_last_dom |=> st[g].wake == WK_AWAKE && !pins[g].receiveOut)
      else $error("wake not recognized at second dominant");
    a_rx_low_cause: assert property (pins[g].weakGroundBias && !pins[g].receiveOut |-> st[g].wake == WK_AWAKE)
      else $error("wake request without recognized pattern");
    a_window_expire: assert property (clkEnable && sbVec[g] && st[g].standby && st[g].wake == WK_WAIT_REC
        && st[g].windowCnt == WINDOW_CYC - 20'h0_0001 |=> st[g].wake == WK_IDLE)
      else $error("pattern window did not reset detector");
    a_dto_off: assert property (st[g].dtoTrip |-> !pins[g].driveDominant && !pins[g].driverEnable)
      else $error("driver on after dominant timeout");
    // independent count of consecutive dominant samples, so the check does not reuse the filter's own counter
    logic [5:0] domRun;
    always_ff @(posedge core_clk)
    begin
      if (reset)
        domRun <= RUN_RST;
      else if (clkEnable)
        domRun <= !busVec[g] ? RUN_RST : ((domRun == FILTER_CYC) ? domRun : domRun + 6'h1);
    end

    a_filter_run: assert property (filtDom[g] |-> busVec[g] && domRun == FILTER_CYC)
      else $error("filtered dominant without held level");
  end

endmodule

// file: ctw_pkg.sv
// constants and carrier types for the dual-channel transceiver mode and wake logic
package ctw_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ            = 25;    // core_clk rate, 40 ns period
  localparam int WAKE_FILTER_MIN_NS = 500;   // shorter states never count
  localparam int WAKE_FILTER_MAX_NS = 1800;  // longer states always count
  localparam int WAKE_FILTER_NS     = 1000;  // nominal wake_filter_time, between min and max
  localparam int WAKE_WINDOW_US     = 1000;  // wake_pattern_window
  localparam int DOM_TIMEOUT_US     = 1200;  // dominant_timeout_period

  // longest-time figures round down to whole cycles
  localparam logic [5:0]  FILTER_CYC      = 6'((WAKE_FILTER_NS * CLK_MHZ) / 1000);
  localparam logic [19:0] WINDOW_CYC_DEF  = 20'(WAKE_WINDOW_US * CLK_MHZ);
  localparam logic [19:0] DOM_TIMEOUT_DEF = 20'(DOM_TIMEOUT_US * CLK_MHZ);

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int          NUM_CH     = 2;
  localparam int          BUF_DEPTH  = 2;
  localparam logic [5:0]  RUN_RST    = 6'h0;
  localparam logic [19:0] CNT_RST    = 20'h0_0000;
  localparam logic [1:0]  MASK_NONE  = 2'h0;
  localparam logic [1:0]  FILL_EMPTY = 2'h0;
  localparam logic [1:0]  FILL_FULL  = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {WK_IDLE, WK_WAIT_REC, WK_WAIT_DOM, WK_AWAKE} ctw_wake_t;

  // per-channel state
  typedef struct packed {
    logic        standby;   // registered mode
    logic        lastBus;   // previous bus sample, 1 = dominant
    logic [5:0]  runCnt;    // samples the bus has held its level
    ctw_wake_t   wake;      // wake detector state
    logic [19:0] windowCnt; // time since first filtered dominant
    logic        rxLow;     // wake request holding receive data low
    logic        lastTx;    // previous transmit sample
    logic [19:0] dtoCnt;    // dominant timeout count
    logic        dtoTrip;   // driver held off by the dominant guard
  } ctw_chan_t;

  // per-channel pin outputs
  typedef struct packed {
    logic receiveOut;
    logic driveDominant;
    logic driverEnable;
    logic weakGroundBias;
  } ctw_pins_t;

endpackage
